// [src/arbs_pkg.sv]
/*
  Shared constants of the converter result sequencer: widths, slot count,
  the DMA block length and reset values.
  Assumes a single clock domain at 10 MHz and an active-low asynchronous reset.
*/
package arbs_pkg;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_PERIOD_NS = 100;

  // ***************************************************************
  // Widths and counts
  // ***************************************************************
  localparam int RESULT_W      = 12;
  localparam int SLOT_COUNT    = 16;
  localparam int SLOT_IDX_W    = 4;
  localparam int PER_EVENT_W   = 5;
  localparam int DMA_BLOCK     = 32;
  localparam int DMA_CNT_W     = 5;
  localparam int FIFO_DEPTH    = 2;

  // ***************************************************************
  // Reset values and fixed slots
  // ***************************************************************
  localparam logic [SLOT_IDX_W-1:0]  SLOT_FIRST    = 4'h0;
  localparam logic [SLOT_IDX_W-1:0]  SLOT_LAST     = 4'hF;
  localparam logic [PER_EVENT_W-1:0] EVENT_CNT_RST = 5'h00;
  localparam logic [DMA_CNT_W-1:0]   DMA_CNT_RST   = 5'h00;
  localparam logic [DMA_CNT_W-1:0]   DMA_CNT_LAST  = 5'h1F;
  localparam logic [RESULT_W-1:0]    RESULT_RST    = 12'h000;

endpackage

// [src/arbs_fifo2.sv]
/*
  Small valid/ready buffer that sits in the DMA result path.
  Assumes the writer honours in_ready_out and the reader may stall at will.
*/
`timescale 1ns/1ps

module arbs_fifo2 #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 2
) (
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST_C = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [PW:0]      count_r;
  logic             push;
  logic             pop;

  function automatic logic [PW-1:0] arbs_wrap_inc(input logic [PW-1:0] p);
    arbs_wrap_inc = (p == LAST_C) ? '0 : p + 1'b1;
  endfunction

  assign in_ready_out  = (count_r != DEPTH_C);
  assign out_valid_out = (count_r != '0);
  assign out_data_out  = mem_r[rd_ptr_r];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_r[i] <= '0;
      end
    end
    else if (push)
    begin
      mem_r[wr_ptr_r] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= arbs_wrap_inc(wr_ptr_r);
      end
      if (pop)
      begin
        rd_ptr_r <= arbs_wrap_inc(rd_ptr_r);
      end
      if (push && !pop)
      begin
        count_r <= count_r + 1'b1;
      end
      else if (pop && !push)
      begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule

// [src/arbs_slot_store.sv]
/*
  Result slots held in flip-flops, one write port and one registered read port.
  Assumes indices are valid slot numbers; a write and a read may share a cycle.
*/
`timescale 1ns/1ps

module arbs_slot_store #(
  parameter int WIDTH = 12,
  parameter int SLOTS = 16,
  parameter int IDX_W = 4
) (
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic             wr_en_in,
  input  wire logic [IDX_W-1:0] wr_index_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic [IDX_W-1:0] rd_index_in,
  output logic [WIDTH-1:0]      rd_data_out
);

  logic [WIDTH-1:0] slot_r [SLOTS];

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      for (int i = 0; i < SLOTS; i++)
      begin
        slot_r[i] <= '0;
      end
    end
    else if (wr_en_in)
    begin
      slot_r[wr_index_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rd_data_out <= '0;
    end
    else
    begin
      rd_data_out <= slot_r[rd_index_in];
    end
  end

endmodule

// [src/arbs_top.sv]
/*
  Result routing and sequencing around a converter core: slot pointer,
  per-event interrupt and scan restart, DMA single-slot mode with address
  advance, and the conversion-done flag.
  Assumes the converter core gives one-cycle start and done pulses in the
  clk_in domain, and that configuration inputs change only between conversions.
*/
`timescale 1ns/1ps

module arbs_top #(
  parameter int RESULT_W = arbs_pkg::RESULT_W
) (
  input  wire logic                               clk_in,
  input  wire logic                               rst_b_in,
  input  wire logic                               conv_start_in,
  input  wire logic                               conv_done_in,
  input  wire logic [RESULT_W-1:0]                conv_result_in,
  input  wire logic [arbs_pkg::PER_EVENT_W-1:0]   conversions_per_event_in,
  input  wire logic                               channel_scan_enable_in,
  input  wire logic                               dma_mode_select_in,
  input  wire logic                               int_enable_in,
  input  wire logic                               done_clear_in,
  input  wire logic [arbs_pkg::SLOT_IDX_W-1:0]    rd_index_in,
  input  wire logic                               dma_ready_in,
  output logic                                    conv_ready_out,
  output logic                                    done_flag_out,
  output logic                                    int_flag_out,
  output logic                                    irq_out,
  output logic                                    scan_restart_out,
  output logic                                    dma_addr_advance_out,
  output logic                                    overrun_out,
  output logic [arbs_pkg::SLOT_IDX_W-1:0]         slot_ptr_out,
  output logic [RESULT_W-1:0]                     rd_data_out,
  output logic                                    dma_valid_out,
  output logic [RESULT_W-1:0]                     dma_data_out
);

  // ***************************************************************
  // Declarations
  // ***************************************************************
  logic [arbs_pkg::SLOT_IDX_W-1:0]  slot_ptr_r;
  logic [arbs_pkg::SLOT_IDX_W-1:0]  slot_ptr_nxt;
  logic [arbs_pkg::PER_EVENT_W-1:0] event_cnt_r;
  logic [arbs_pkg::DMA_CNT_W-1:0]   dma_cnt_r;
  logic [arbs_pkg::SLOT_IDX_W-1:0]  wr_index;
  logic                             event_now;
  logic                             fifo_in_ready;
  logic                             fifo_push;
  logic                             done_flag_r;
  logic                             int_flag_r;
  logic                             irq_r;
  logic                             scan_restart_r;
  logic                             dma_adv_r;
  logic                             overrun_r;

  function automatic logic [arbs_pkg::SLOT_IDX_W-1:0] arbs_slot_inc(
    input logic [arbs_pkg::SLOT_IDX_W-1:0] p
  );
    arbs_slot_inc = (p == arbs_pkg::SLOT_LAST) ? arbs_pkg::SLOT_FIRST : p + 1'b1;
  endfunction

  // ***************************************************************
  // Event point
  // ***************************************************************
  // A setting of k makes every (k+1)th completed conversion an event point.
  assign event_now = conv_done_in && (event_cnt_r == conversions_per_event_in);

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      event_cnt_r <= arbs_pkg::EVENT_CNT_RST;
    end
    else if (event_now)
    begin
      event_cnt_r <= arbs_pkg::EVENT_CNT_RST;
    end
    else if (conv_done_in)
    begin
      event_cnt_r <= event_cnt_r + 1'b1;
    end
  end

  // ***************************************************************
  // Slot pointer
  // ***************************************************************
  // Outside DMA mode the slot is taken from the pointer alone, DMA mode writes SLOT_FIRST; the input channel never enters here.
  assign wr_index = dma_mode_select_in ? arbs_pkg::SLOT_FIRST : slot_ptr_r;

  always_comb
  begin
    slot_ptr_nxt = slot_ptr_r;
    if (dma_mode_select_in)
    begin
      slot_ptr_nxt = arbs_pkg::SLOT_FIRST;
    end
    else if (event_now)
    begin
      slot_ptr_nxt = arbs_pkg::SLOT_FIRST;
    end
    else if (conv_done_in)
    begin
      slot_ptr_nxt = arbs_slot_inc(slot_ptr_r);
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      slot_ptr_r <= arbs_pkg::SLOT_FIRST;
    end
    else
    begin
      slot_ptr_r <= slot_ptr_nxt;
    end
  end

  assign slot_ptr_out = slot_ptr_r;

  arbs_slot_store #(
    .WIDTH (RESULT_W),
    .SLOTS (arbs_pkg::SLOT_COUNT),
    .IDX_W (arbs_pkg::SLOT_IDX_W)
  ) i_arbs_slot_store (
    .clk_in      (clk_in),
    .rst_b_in    (rst_b_in),
    .wr_en_in    (conv_done_in),
    .wr_index_in (wr_index),
    .wr_data_in  (conv_result_in),
    .rd_index_in (rd_index_in),
    .rd_data_out (rd_data_out)
  );

  // ***************************************************************
  // DMA path
  // ***************************************************************
  // The buffer absorbs a short reader stall; a longer one shows as overrun,
  // since the converter itself cannot be held off mid-conversion.
  assign fifo_push      = conv_done_in && dma_mode_select_in;
  assign conv_ready_out = !dma_mode_select_in || fifo_in_ready;

  arbs_fifo2 #(
    .WIDTH (RESULT_W),
    .DEPTH (arbs_pkg::FIFO_DEPTH)
  ) i_arbs_fifo2 (
    .clk_in        (clk_in),
    .rst_b_in      (rst_b_in),
    .in_valid_in   (fifo_push),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (conv_result_in),
    .out_valid_out (dma_valid_out),
    .out_ready_in  (dma_ready_in),
    .out_data_out  (dma_data_out)
  );

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      dma_cnt_r <= arbs_pkg::DMA_CNT_RST;
      dma_adv_r <= 1'b0;
    end
    else
    begin
      dma_adv_r <= fifo_push && (dma_cnt_r == arbs_pkg::DMA_CNT_LAST);
      if (!dma_mode_select_in)
      begin
        dma_cnt_r <= arbs_pkg::DMA_CNT_RST;
      end
      else if (fifo_push)
      begin
        dma_cnt_r <= dma_cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      overrun_r <= 1'b0;
    end
    else
    begin
      overrun_r <= fifo_push && !fifo_in_ready;
    end
  end

  assign dma_addr_advance_out = dma_adv_r;
  assign overrun_out          = overrun_r;

  // ***************************************************************
  // Event outputs
  // ***************************************************************
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      int_flag_r     <= 1'b0;
      irq_r          <= 1'b0;
      scan_restart_r <= 1'b0;
    end
    else
    begin
      int_flag_r     <= event_now;
      irq_r          <= event_now && int_enable_in;
      scan_restart_r <= event_now && channel_scan_enable_in;
    end
  end

  assign int_flag_out     = int_flag_r;
  assign irq_out          = irq_r;
  assign scan_restart_out = scan_restart_r;

  // ***************************************************************
  // Done flag
  // ***************************************************************
  // Completion wins over a clear in the same cycle so a result is never hidden.
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      done_flag_r <= 1'b0;
    end
    else if (conv_done_in)
    begin
      done_flag_r <= 1'b1;
    end
    else if (conv_start_in || done_clear_in)
    begin
      done_flag_r <= 1'b0;
    end
  end

  assign done_flag_out = done_flag_r;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  property p_irq_on_event;
    @(posedge clk_in) disable iff (!rst_b_in)
    event_now |=> (irq_out == $past(int_enable_in)) && int_flag_out;
  endproperty
  a_irq_on_event: assert property (p_irq_on_event) else $error("interrupt not raised at event");

  property p_irq_cause;
    @(posedge clk_in) disable iff (!rst_b_in)
    irq_out |-> $past(event_now) && $past(int_enable_in);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without enabled event");

  property p_scan_restart;
    @(posedge clk_in) disable iff (!rst_b_in)
    scan_restart_out |-> $past(event_now) && $past(channel_scan_enable_in);
  endproperty
  a_scan_restart: assert property (p_scan_restart) else $error("scan restart without event");

  property p_ptr_reset;
    @(posedge clk_in) disable iff (!rst_b_in)
    (event_now && !dma_mode_select_in) |=> (slot_ptr_out == arbs_pkg::SLOT_FIRST);
  endproperty
  a_ptr_reset: assert property (p_ptr_reset) else $error("slot pointer not reset at event");

  property p_dma_adv_only;
    @(posedge clk_in) disable iff (!rst_b_in)
    dma_addr_advance_out |-> $past(dma_mode_select_in) && $past(conv_done_in);
  endproperty
  a_dma_adv_only: assert property (p_dma_adv_only) else $error("dma advance outside dma mode");

  property p_dma_adv_32;
    @(posedge clk_in) disable iff (!rst_b_in)
    (fifo_push && dma_cnt_r == arbs_pkg::DMA_CNT_LAST) |=> dma_addr_advance_out && (dma_cnt_r == arbs_pkg::DMA_CNT_RST);
  endproperty
  a_dma_adv_32: assert property (p_dma_adv_32) else $error("dma advance not on 32nd result");

  property p_dma_slot_first;
    @(posedge clk_in) disable iff (!rst_b_in)
    dma_mode_select_in |-> (wr_index == arbs_pkg::SLOT_FIRST);
  endproperty
  a_dma_slot_first: assert property (p_dma_slot_first) else $error("dma result not in first slot");

  property p_ptr_step;
    @(posedge clk_in) disable iff (!rst_b_in)
    (conv_done_in && !event_now && !dma_mode_select_in) |=> (slot_ptr_out == arbs_slot_inc($past(slot_ptr_out)));
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("slot pointer did not step");

  property p_ptr_by_order;
    @(posedge clk_in) disable iff (!rst_b_in)
    !dma_mode_select_in |-> (wr_index == slot_ptr_out);
  endproperty
  a_ptr_by_order: assert property (p_ptr_by_order) else $error("slot not chosen by order");

  property p_done_set_hold;
    @(posedge clk_in) disable iff (!rst_b_in)
    conv_done_in ##1 (!conv_start_in && !done_clear_in) [*2] |-> done_flag_out;
  endproperty
  a_done_set_hold: assert property (p_done_set_hold) else $error("done flag lost before start");

  property p_done_clear_start;
    @(posedge clk_in) disable iff (!rst_b_in)
    (conv_start_in && !conv_done_in) |=> !done_flag_out;
  endproperty
  a_done_clear_start: assert property (p_done_clear_start) else $error("done flag not cleared at start");

  c_event_irq: cover property (@(posedge clk_in) disable iff (!rst_b_in) irq_out && scan_restart_out);
  c_ptr_wrap: cover property (@(posedge clk_in) disable iff (!rst_b_in)
    slot_ptr_out == arbs_pkg::SLOT_LAST ##1 slot_ptr_out == arbs_pkg::SLOT_FIRST);
  c_dma_adv: cover property (@(posedge clk_in) disable iff (!rst_b_in) dma_addr_advance_out);
  c_overrun: cover property (@(posedge clk_in) disable iff (!rst_b_in) overrun_out);

endmodule

// [sim/arbs_reader_model.sv]
/*
  Behavioural DMA reader on the far side of the result stream.
  Assumes a word moves on a rising edge where valid and ready are both high.
*/
`timescale 1ns/1ps

module arbs_reader_model (
  input  wire logic                          clk_in,
  input  wire logic                          rst_b_in,
  input  wire logic                          stall_in,
  input  wire logic                          dma_valid_in,
  input  wire logic [arbs_pkg::RESULT_W-1:0] dma_data_in,
  output logic                               dma_ready_out
);
  logic [arbs_pkg::RESULT_W-1:0] got_q[$];

  // The reader fetches every word at once; only a test may stall it.
  assign dma_ready_out = !stall_in;

  always @(posedge clk_in)
  begin
    if (rst_b_in && dma_valid_in && dma_ready_out)
    begin
      got_q.push_back(dma_data_in);
    end
  end
endmodule

// [sim/arbs_top_tb.sv]
/*
  Self-checking bench for the converter result sequencer.
  Assumes the design's converter pulses and the reader model beside it.
*/
`timescale 1ns/1ps

module arbs_top_tb;
  logic        clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        conv_start = 1'b0;
  logic        conv_done = 1'b0;
  logic [11:0] conv_result = 12'h000;
  logic [4:0]  cpe = 5'h00;
  logic        scan_en = 1'b0;
  logic        dma_sel = 1'b0;
  logic        int_en = 1'b0;
  logic        done_clr = 1'b0;
  logic [3:0]  rd_idx = 4'h0;
  logic        stall = 1'b0;
  logic        dma_ready, conv_ready, done_flag, int_flag, irq, scan_rst, adv, ovr, dma_valid;
  logic [3:0]  slot_ptr;
  logic [11:0] rd_data, dma_data, d;
  logic        o_int, o_irq, o_scan, o_adv, o_ovr, ev;
  int          miscompares = 0;
  int          n_tests = 0;
  int          i, p, w;

  always #(arbs_pkg::CLK_PERIOD_NS / 2) clk_in = ~clk_in;

  arbs_top i_arbs_top (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .conv_start_in(conv_start), .conv_done_in(conv_done),
    .conv_result_in(conv_result), .conversions_per_event_in(cpe), .channel_scan_enable_in(scan_en),
    .dma_mode_select_in(dma_sel), .int_enable_in(int_en), .done_clear_in(done_clr),
    .rd_index_in(rd_idx), .dma_ready_in(dma_ready), .conv_ready_out(conv_ready),
    .done_flag_out(done_flag), .int_flag_out(int_flag), .irq_out(irq), .scan_restart_out(scan_rst),
    .dma_addr_advance_out(adv), .overrun_out(ovr), .slot_ptr_out(slot_ptr), .rd_data_out(rd_data),
    .dma_valid_out(dma_valid), .dma_data_out(dma_data)
  );

  arbs_reader_model i_arbs_reader_model (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .stall_in(stall), .dma_valid_in(dma_valid),
    .dma_data_in(dma_data), .dma_ready_out(dma_ready)
  );

  // ***************************************************************
  // Compare, access and report tasks
  // ***************************************************************
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Pulses stand one cycle, so they are captured just after the answering edge.
  task automatic conv(input logic [11:0] res);
    @(posedge clk_in);
    conv_done <= 1'b1;
    conv_result <= res;
    @(posedge clk_in);
    conv_done <= 1'b0;
    #1;
    o_int = int_flag;
    o_irq = irq;
    o_scan = scan_rst;
    o_adv = adv;
    o_ovr = ovr;
  endtask

  task automatic rd(input logic [3:0] idx, output logic [11:0] val);
    @(posedge clk_in);
    rd_idx <= idx;
    @(posedge clk_in);
    #1;
    val = rd_data;
  endtask

  task automatic test_end(input string name);
    $display("Test %s done, mismatches so far %0d", name, miscompares);
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial
  begin
    repeat (2) @(posedge clk_in);
    chk_bit(conv_ready, 1'b1);
    chk_bit(done_flag, 1'b0);
    rst_b_in <= 1'b1;
    for (p = 0; p < 2; p++)
    begin
      @(posedge clk_in);
      cpe <= 5'h03;
      int_en <= p[0];
      scan_en <= !p[0];
      for (i = 0; i < 8; i++)
      begin
        conv(12'(12'h100 + i));
        ev = (i % 4 == 3);
        chk_bit(o_int, ev);
        chk_bit(o_irq, ev && p[0]);
        chk_bit(o_scan, ev && !p[0]);
        chk_val(12'(slot_ptr), ev ? 12'h000 : 12'(i % 4 + 1));
      end
    end
    test_end("event points");

    // The longest event spacing keeps the slot wrap apart from the event reset.
    @(posedge clk_in);
    cpe <= 5'h1F;
    for (i = 0; i < 16; i++)
    begin
      conv(12'(12'h321 + i * 12'h0F3));
      chk_val(12'(slot_ptr), 12'((i + 1) % 16));
      chk_bit(o_int, 1'b0);
    end
    for (i = 0; i < 16; i++)
    begin
      rd(4'(i), d);
      chk_val(d, 12'(12'h321 + i * 12'h0F3));
    end
    conv(12'hABC);
    chk_val(12'(slot_ptr), 12'h001);
    rd(4'h0, d);
    chk_val(d, 12'hABC);
    test_end("slot fill and wrap");

    @(posedge clk_in);
    conv_start <= 1'b1;
    @(posedge clk_in);
    conv_start <= 1'b0;
    #1;
    chk_bit(done_flag, 1'b0);
    repeat (3) @(posedge clk_in);
    chk_bit(done_flag, 1'b0);
    conv(12'h055);
    chk_bit(done_flag, 1'b1);
    repeat (5) @(posedge clk_in);
    chk_bit(done_flag, 1'b1);
    done_clr <= 1'b1;
    @(posedge clk_in);
    done_clr <= 1'b0;
    #1;
    chk_bit(done_flag, 1'b0);
    @(posedge clk_in);
    conv_start <= 1'b1;
    conv_done <= 1'b1;
    @(posedge clk_in);
    conv_start <= 1'b0;
    conv_done <= 1'b0;
    #1;
    chk_bit(done_flag, 1'b1);
    test_end("done flag");

    // Earlier tests leave 19 counted conversions, so the 13th result here is an event point.
    @(posedge clk_in);
    dma_sel <= 1'b1;
    scan_en <= 1'b1;
    for (i = 1; i <= 32; i++)
    begin
      conv(12'(12'h800 + i));
      chk_bit(o_adv, i == 32);
      chk_bit(o_irq, i == 13);
      chk_bit(o_scan, i == 13);
      chk_val(12'(slot_ptr), 12'h000);
    end
    repeat (2) @(posedge clk_in);
    chk_val(12'(i_arbs_reader_model.got_q.size()), 12'h020);
    for (i = 0; i < 32; i++)
      chk_val(i_arbs_reader_model.got_q[i], 12'(12'h801 + i));
    rd(4'h0, d);
    chk_val(d, 12'h820);
    test_end("dma stream");

    // A stalled reader fills the buffer; the third word is refused but kept in the slot.
    @(posedge clk_in);
    stall <= 1'b1;
    conv(12'h3A1);
    chk_bit(conv_ready, 1'b1);
    conv(12'h3A2);
    chk_bit(conv_ready, 1'b0);
    chk_bit(o_ovr, 1'b0);
    conv(12'h3A3);
    chk_bit(o_ovr, 1'b1);
    rd(4'h0, d);
    chk_val(d, 12'h3A3);
    @(posedge clk_in);
    stall <= 1'b0;
    w = 0;
    while (dma_valid !== 1'b0 && w < 10)
    begin
      @(posedge clk_in);
      #1;
      w++;
    end
    if (w == 10)
    begin
      miscompares++;
    end
    chk_val(12'(i_arbs_reader_model.got_q.size()), 12'h022);
    chk_val(i_arbs_reader_model.got_q[32], 12'h3A1);
    chk_val(i_arbs_reader_model.got_q[33], 12'h3A2);
    chk_bit(conv_ready, 1'b1);
    test_end("dma stall");
    tally_and_finish();
  end
endmodule
